// file: ohi_host_if.sv
// ohi_host_if: host pin front end, strap-selected i2c / spi / parallel,
// bytes tagged data or command handed to the core through a two-entry buffer
// assumes host pins are asynchronous, sampled on link_clk; rd_data quasi-static
//
// Contract
// - straps 010 select i2c, 100 three-wire spi, 000 four-wire spi
// - straps 001 select enable-strobe parallel, 011 separate-strobe parallel
// - device talks to host only while chip select is low
// - reset pin low returns all logic to initial state
// - parallel byte is display data when d/c high, command when low
// - serial bits are display data when d/c high, command when low; spi3 takes d/c from its first bit, i2c from the control byte
// - in i2c the d/c pin is the slave address lsb
// - enable-strobe mode: direction high reads, low writes, enable high starts
// - separate-strobe mode: write strobe low writes, read strobe low reads
// - serial: bit1 data in, bit0 clock; i2c: bit2 sda out, bit1 in
`timescale 1ns/1ps
module ohi_host_if import ohi_pkg::*; (
  // core clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // link sampling clock
  input wire logic link_clk,
  // host pins
  input wire logic iface_strap_0,
  input wire logic iface_strap_1,
  input wire logic iface_strap_2,
  input wire logic reset_n_input,
  input wire logic chip_sel_n,
  input wire logic data_cmd_sel,
  input wire logic rw_wr_n,
  input wire logic en_rd_n,
  input wire logic [7:0] host_data_bus_in,
  output logic [7:0] host_data_bus_out,
  output logic [7:0] host_data_bus_oe,
  // core side
  input wire logic [7:0] rd_data,
  output logic [7:0] out_byte,
  output logic out_is_data,
  output logic out_valid,
  input wire logic out_ready,
  output ohi_mode_e iface_mode
);

  // ----------------------------------------
  // link domain: synchronisers
  // ----------------------------------------
  logic [14:0] pin_s1, pin_s2;
  logic [7:0] rdd_s1, rdd_s2;
  logic [1:0] lrst_s1, lrst_s2;
  logic ack_s1, ack_s2;
  logic seen_q;
  // every pin passes two flops before use
  always_ff @(posedge link_clk) begin
    pin_s1 <= {iface_strap_0, iface_strap_1, iface_strap_2, chip_sel_n, data_cmd_sel,
               rw_wr_n, en_rd_n, host_data_bus_in};
    pin_s2 <= pin_s1;
    rdd_s1 <= rd_data;
    rdd_s2 <= rdd_s1;
    lrst_s1 <= {rst_b, reset_n_input};
    lrst_s2 <= lrst_s1;
    ack_s1 <= seen_q;
    ack_s2 <= ack_s1;
  end

  // named views of the sampled pins
  wire logic [2:0] strap_l = pin_s2[14:12];
  wire logic cs_l = pin_s2[11];
  wire logic dc_l = pin_s2[10];
  wire logic rw_l = pin_s2[9];
  wire logic en_l = pin_s2[8];
  wire logic [7:0] d_l = pin_s2[7:0] & 8'hff;
  wire logic [7:0] db_l = {pin_s2[7:0]};
  wire logic slave_addr_bit = dc_l;
  wire logic i2c_data_in_line = db_l[DB_SDI];
  wire logic link_rst = !(&lrst_s2);

  // previous samples for edge detection
  logic rw_p, en_p, sck_p, sda_p;
  always_ff @(posedge link_clk) begin
    rw_p <= rw_l;
    en_p <= en_l;
    sck_p <= db_l[DB_SCK];
    sda_p <= i2c_data_in_line;
  end

  // ----------------------------------------
  // link domain: mode and strobes
  // ----------------------------------------
  ohi_mode_e lmode_q;
  // straps caught while held in reset
  always_ff @(posedge link_clk) begin
    if (link_rst) lmode_q <= ohi_decode(strap_l);
  end

  wire logic sel_w = !cs_l;
  wire logic par_e_w = (lmode_q == OHI_PAR_E);
  wire logic par_s_w = (lmode_q == OHI_PAR_S);
  wire logic spi_w = (lmode_q == OHI_SPI4) || (lmode_q == OHI_SPI3);
  wire logic i2c_w = (lmode_q == OHI_I2C);
  // enable falls with direction low: write ends
  wire logic par_e_wr = par_e_w && sel_w && en_p && !en_l && !rw_l;
  // write strobe rises: write ends
  wire logic par_s_wr = par_s_w && sel_w && !rw_p && rw_l;
  wire logic rd_w = sel_w && ((par_e_w && en_l && rw_l) || (par_s_w && !en_l));
  wire logic sck_rise = sel_w && !sck_p && db_l[DB_SCK];
  wire logic sck_fall = sel_w && sck_p && !db_l[DB_SCK];
  wire logic i2c_start = i2c_w && sel_w && sck_p && db_l[DB_SCK] && sda_p && !i2c_data_in_line;
  wire logic i2c_stop = i2c_w && sck_p && db_l[DB_SCK] && !sda_p && i2c_data_in_line;

  // ----------------------------------------
  // link domain: serial shifter
  // ----------------------------------------
  logic [8:0] sh_q;
  logic [3:0] cnt_q;
  wire logic [7:0] ser_byte = {sh_q[6:0], i2c_data_in_line};
  wire logic spi4_done = spi_w && sck_rise && (lmode_q == OHI_SPI4) && (cnt_q == SPI4_LAST);
  wire logic spi3_done = spi_w && sck_rise && (lmode_q == OHI_SPI3) && (cnt_q == SPI3_LAST);
  wire logic i2c_byte = i2c_w && sck_rise && (cnt_q == I2C_LAST);
  // bit counter restarts on deselect, start or end of i2c ack
  always_ff @(posedge link_clk) begin
    if (link_rst || !sel_w || i2c_start || spi4_done || spi3_done) cnt_q <= CNT_RST;
    else if (i2c_w && sck_fall && cnt_q == I2C_DONE) cnt_q <= CNT_RST;
    else if ((spi_w || i2c_w) && sck_rise) cnt_q <= cnt_q + 4'h1;
  end
  // shift serial data in on clock rise
  always_ff @(posedge link_clk) begin
    if (link_rst) sh_q <= 9'h000;
    else if (sck_rise) sh_q <= {sh_q[7:0], i2c_data_in_line};
  end

  // ----------------------------------------
  // link domain: i2c slave
  // ----------------------------------------
  ohi_i2c_e ist_q;
  logic ctl_dc_q, ctl_co_q, ack_q, acc_q;
  wire logic addr_hit = (ser_byte[7:1] == {I2C_ADDR_HI, slave_addr_bit}) && !ser_byte[0];
  wire logic i2c_fire = i2c_byte && (ist_q == I_DATA);
  // state steps on each completed byte
  always_ff @(posedge link_clk) begin
    if (link_rst || i2c_stop || !sel_w) ist_q <= I_IDLE;
    else if (i2c_start) ist_q <= I_ADDR;
    else if (i2c_byte) begin
      case (ist_q)
        I_ADDR: ist_q <= addr_hit ? I_CTRL : I_SKIP;
        I_CTRL: ist_q <= I_DATA;
        I_DATA: ist_q <= ctl_co_q ? I_CTRL : I_DATA;
        default: ist_q <= ist_q;
      endcase
    end
  end
  // control byte picks the route of following bytes
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      ctl_dc_q <= 1'b0;
      ctl_co_q <= 1'b0;
    end else if (i2c_byte && ist_q == I_CTRL) begin
      ctl_dc_q <= ser_byte[CTRL_DC];
      ctl_co_q <= ser_byte[CTRL_CO];
    end
  end
  // ack pulls sda low across the ninth clock
  always_ff @(posedge link_clk) begin
    if (link_rst || !i2c_w) acc_q <= 1'b0;
    else if (i2c_byte) acc_q <= (ist_q == I_ADDR) ? addr_hit : ((ist_q == I_CTRL) || (ist_q == I_DATA));
  end
  always_ff @(posedge link_clk) begin
    if (link_rst || !sel_w || i2c_stop) ack_q <= 1'b0;
    else if (sck_fall && cnt_q == I2C_ACK) ack_q <= acc_q;
    else if (sck_fall && cnt_q == I2C_DONE) ack_q <= 1'b0;
  end

  // ----------------------------------------
  // link domain: byte select and hand-off
  // ----------------------------------------
  wire logic fire_w = par_e_wr || par_s_wr || spi4_done || spi3_done || i2c_fire;
  wire logic [7:0] byte_w = (par_e_w || par_s_w) ? d_l : (spi3_done ? sh_q[7:0] & 8'hff : ser_byte);
  wire logic [7:0] spi3_b = {sh_q[6:0], i2c_data_in_line};
  wire logic [7:0] fire_b = spi3_done ? spi3_b : byte_w;
  // d/c pin taken with the same sample as the last strobe or spi4 bit; spi3 uses its first bit, i2c the control byte
  wire logic dc_w = i2c_w ? ctl_dc_q : (spi3_done ? sh_q[7] : dc_l);
  logic req_q, hdc_q;
  logic [7:0] hbyte_q;
  wire logic pend_w = (req_q != ack_s2);
  // hold word stable until the core acknowledges
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      req_q <= ack_s2;
      hbyte_q <= BYTE_RST;
      hdc_q <= 1'b0;
    end else if (fire_w && !pend_w) begin
      req_q <= !req_q;
      hbyte_q <= fire_b;
      hdc_q <= dc_w;
    end
  end
  // bus drive: read byte, or the i2c ack on the sda output bit
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      host_data_bus_out <= BYTE_RST;
      host_data_bus_oe <= 8'h00;
    end else begin
      host_data_bus_out <= rd_w ? rdd_s2 : 8'h00;
      host_data_bus_oe <= rd_w ? 8'hff : {5'h00, ack_q, 2'h0};
    end
  end
  wire logic i2c_data_out_line = host_data_bus_out[DB_SDO];

  // ----------------------------------------
  // core domain: reset, straps, hand-off receive
  // ----------------------------------------
  logic [2:0] strap_s1, strap_s2;
  logic resn_s1, resn_s2, req_s1, req_s2;
  always_ff @(posedge core_clk) begin
    strap_s1 <= {iface_strap_0, iface_strap_1, iface_strap_2};
    strap_s2 <= strap_s1;
    resn_s1 <= reset_n_input;
    resn_s2 <= resn_s1;
    req_s1 <= req_q;
    req_s2 <= req_s1;
  end
  wire logic core_rst = !rst_b || !resn_s2;
  always_ff @(posedge core_clk) begin
    if (core_rst) iface_mode <= ohi_decode(strap_s2);
  end

  // ----------------------------------------
  // core domain: two-entry buffer, head drives the outputs
  // ----------------------------------------
  logic skid_v_q, skid_dc_q;
  logic [7:0] skid_b_q;
  wire logic in_ready = !skid_v_q;
  wire logic push_w = (req_s2 != seen_q) && in_ready;
  wire logic pop_w = out_valid && out_ready;
  wire logic head_load = !out_valid || pop_w;
  always_ff @(posedge core_clk) begin
    if (core_rst) seen_q <= 1'b0;
    else if (push_w) seen_q <= !seen_q;
  end
  // head register: refill from skid first, then from the link
  always_ff @(posedge core_clk) begin
    if (core_rst) begin
      out_valid <= 1'b0;
      out_byte <= BYTE_RST;
      out_is_data <= 1'b0;
    end else if (head_load) begin
      out_valid <= skid_v_q || push_w;
      out_byte <= skid_v_q ? skid_b_q : hbyte_q;
      out_is_data <= skid_v_q ? skid_dc_q : hdc_q;
    end
  end
  // skid register catches a word while the head is stalled
  always_ff @(posedge core_clk) begin
    if (core_rst) begin
      skid_v_q <= 1'b0;
      skid_b_q <= BYTE_RST;
      skid_dc_q <= 1'b0;
    end else if (push_w && !head_load) begin
      skid_v_q <= 1'b1;
      skid_b_q <= hbyte_q;
      skid_dc_q <= hdc_q;
    end else if (head_load) skid_v_q <= 1'b0;
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence addr_hit_s;
    ist_q == I_ADDR && i2c_byte && addr_hit;
  endsequence
  sequence addr_miss_s;
    ist_q == I_ADDR && i2c_byte && !addr_hit && !i2c_stop && sel_w;
  endsequence
  strap_i2c_a: assert property (@(posedge core_clk) (core_rst && strap_s2 == STRAP_I2C) |=> iface_mode == OHI_I2C)
    else $error("i2c strap not decoded");
  strap_par_a: assert property (@(posedge core_clk) (core_rst && strap_s2 == STRAP_PAR_S) |=> iface_mode == OHI_PAR_S)
    else $error("separate strobe strap not decoded");
  cs_gate_a: assert property (@(posedge link_clk) disable iff (link_rst) fire_w |-> !cs_l)
    else $error("byte taken while deselected");
  reset_clear_a: assert property (@(posedge core_clk) core_rst |=> !out_valid && !skid_v_q)
    else $error("buffer not cleared by reset");
  par_route_a: assert property (@(posedge link_clk) disable iff (link_rst)
    (par_e_wr && !pend_w) |=> hdc_q == $past(dc_l) && hbyte_q == $past(d_l))
    else $error("parallel byte misrouted");
  spi_route_a: assert property (@(posedge link_clk) disable iff (link_rst)
    (spi4_done && !pend_w) |=> hdc_q == $past(dc_l) && hbyte_q == $past(ser_byte))
    else $error("serial byte misrouted");
  i2c_addr_a: assert property (@(posedge link_clk) disable iff (link_rst) addr_hit_s |=> ist_q == I_CTRL)
    else $error("own address not accepted");
  i2c_miss_a: assert property (@(posedge link_clk) disable iff (link_rst) addr_miss_s |=> ist_q == I_SKIP)
    else $error("foreign address accepted");
  read_drive_a: assert property (@(posedge link_clk) disable iff (link_rst)
    host_data_bus_oe == 8'hff |-> $past(rd_w) && !$past(cs_l))
    else $error("bus driven without read");
  sep_write_a: assert property (@(posedge link_clk) disable iff (link_rst)
    (par_s_w && sel_w && !rw_p && rw_l) |-> fire_w)
    else $error("write strobe missed");
  ack_bit_a: assert property (@(posedge link_clk) disable iff (link_rst)
    ack_q && !rd_w |=> host_data_bus_oe == 8'h04 && i2c_data_out_line == 1'b0)
    else $error("ack not on sda output bit");
  dc_hold_a: assert property (@(posedge link_clk) disable iff (link_rst)
    pend_w && !fire_w |=> $stable(hdc_q) && $stable(hbyte_q))
    else $error("held word changed while pending");

endmodule

// file: ohi_pkg.sv
// ohi_pkg: constants, modes and strap decode for the host interface front end
// assumes straps are wired {strap0,strap1,strap2} into a 3-bit vector
package ohi_pkg;

  // host interface modes, gray along spi4 -> spi3 -> i2c -> par
  typedef enum logic [2:0] {
    OHI_SPI4  = 3'h0,
    OHI_SPI3  = 3'h1,
    OHI_I2C   = 3'h3,
    OHI_PAR_E = 3'h2,
    OHI_PAR_S = 3'h6,
    OHI_BAD   = 3'h7
  } ohi_mode_e;

  // i2c slave states
  typedef enum logic [2:0] {
    I_IDLE = 3'h0,
    I_ADDR = 3'h1,
    I_CTRL = 3'h3,
    I_DATA = 3'h2,
    I_SKIP = 3'h6
  } ohi_i2c_e;

  // strap patterns as {strap0,strap1,strap2}
  localparam logic [2:0] STRAP_I2C = 3'h2;
  localparam logic [2:0] STRAP_SPI3 = 3'h4;
  localparam logic [2:0] STRAP_SPI4 = 3'h0;
  localparam logic [2:0] STRAP_PAR_E = 3'h1;
  localparam logic [2:0] STRAP_PAR_S = 3'h3;

  // upper six bits of the i2c slave address, lsb comes from the d/c pin
  localparam logic [5:0] I2C_ADDR_HI = 6'h1e;

  // bit counts on the serial links
  localparam logic [3:0] SPI4_LAST = 4'h7;
  localparam logic [3:0] SPI3_LAST = 4'h8;
  localparam logic [3:0] I2C_LAST = 4'h7;
  localparam logic [3:0] I2C_ACK = 4'h8;
  localparam logic [3:0] I2C_DONE = 4'h9;

  // data bus bit positions and control byte fields
  localparam int DB_SCK = 0;
  localparam int DB_SDI = 1;
  localparam int DB_SDO = 2;
  localparam int CTRL_CO = 7;
  localparam int CTRL_DC = 6;

  // values after reset
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [3:0] CNT_RST = 4'h0;

  // strap decode, used by both clock domains
  function automatic ohi_mode_e ohi_decode(input logic [2:0] s);
    case (s)
      STRAP_I2C: ohi_decode = OHI_I2C;
      STRAP_SPI3: ohi_decode = OHI_SPI3;
      STRAP_SPI4: ohi_decode = OHI_SPI4;
      STRAP_PAR_E: ohi_decode = OHI_PAR_E;
      STRAP_PAR_S: ohi_decode = OHI_PAR_S;
      default: ohi_decode = OHI_BAD;
    endcase
  endfunction

endpackage

// file: ohi_host_model.sv
// ohi_host_model: host controller pins for parallel and spi transfers
// assumes it is paced by link_clk and that the bench calls its tasks
`timescale 1ns/1ps
module ohi_host_model (
  // pacing clock
  input wire logic link_clk,
  // host pins
  output logic cs_n,
  output logic dc,
  output logic rw,
  output logic en,
  output logic [7:0] bus
);
  initial begin
    cs_n = 1'b1;
    dc = 1'b0;
    rw = 1'b0;
    en = 1'b0;
    bus = 8'h00;
  end

  // ----------------------------------------
  // pin sequences
  // ----------------------------------------
  // wait link edges, then step just after
  task automatic tick(input int n);
    repeat (n) @(posedge link_clk);
    #2;
  endtask

  // idle strobes: separate mode keeps both strobes high
  task automatic idle(input logic sep);
    cs_n = 1'b1;
    rw = sep;
    en = sep;
  endtask

  // one parallel write, held well past the strobe
  task automatic par_wr(input logic sep, input logic c, input logic d, input logic [7:0] b);
    cs_n = c;
    dc = d;
    bus = b;
    tick(1);
    if (!sep) begin
      rw = 1'b0;
      en = 1'b1;
      tick(3);
      en = 1'b0;
    end else begin
      rw = 1'b0;
      tick(3);
      rw = 1'b1;
    end
    tick(4);
    cs_n = 1'b1;
    bus = ~b;
    tick(8);
  endtask

  // read strobe on and off, bus left to the device
  task automatic rd_on(input logic sep);
    cs_n = 1'b0;
    bus = ~bus;
    if (!sep) begin
      rw = 1'b1;
      en = 1'b1;
    end else begin
      en = 1'b0;
    end
  endtask

  // enable drops a link cycle before direction, so the end of a read is never taken as a write
  task automatic rd_off(input logic sep);
    en = sep;
    tick(1);
    rw = sep;
    tick(4);
    cs_n = 1'b1;
  endtask

  // serial bits msb first: bit1 data, bit0 clock idle low
  task automatic ser(input logic c, input logic d, input logic [8:0] v, input int n);
    cs_n = c;
    dc = d;
    bus[0] = 1'b0;
    tick(2);
    for (int i = n - 1; i >= 0; i--) begin
      bus[1] = v[i];
      tick(2);
      bus[0] = 1'b1;
      tick(2);
      bus[0] = 1'b0;
    end
    tick(2);
    cs_n = 1'b1;
    bus[1] = ~bus[1];
    tick(8);
  endtask

  // i2c bit: sda moves four link cycles after scl fell, clear of the slow ack release
  task automatic i2c_bit(input logic v);
    bus[1] = v;
    tick(4);
    bus[0] = 1'b1;
    tick(4);
    bus[0] = 1'b0;
    tick(4);
  endtask

  // i2c write: start, address, control, one data byte, released ack slots, stop
  task automatic i2c_wr(input logic p, input logic [7:0] a, input logic [7:0] c, input logic [7:0] b);
    logic [23:0] w;
    w = {a, c, b};
    cs_n = 1'b1;
    dc = p;
    bus[1:0] = 2'b11;
    tick(4);
    cs_n = 1'b0;
    tick(4);
    bus[1] = 1'b0;
    tick(4);
    bus[0] = 1'b0;
    tick(4);
    for (int i = 23; i >= 0; i--) begin
      i2c_bit(w[i]);
      if (i % 8 == 0) i2c_bit(1'b1);
    end
    bus[1] = 1'b0;
    tick(4);
    bus[0] = 1'b1;
    tick(4);
    bus[1] = 1'b1;
    tick(4);
    cs_n = 1'b1;
    tick(8);
  endtask
endmodule

// file: oled_host_interface_select_tb.sv
// oled_host_interface_select_tb: mode decode, parallel and spi writes, reads
// assumes ohi_pkg and ohi_host_if compiled first
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin failures++; \
  $display("ERROR %0t mismatch got %h exp %h", $time, a, b); end end
module oled_host_interface_select_tb import ohi_pkg::*;;
  logic core_clk, link_clk, rst_b, reset_n_input, out_ready, stall;
  logic iface_strap_0, iface_strap_1, iface_strap_2;
  logic cs_n, dc, rw, en, out_is_data, out_valid;
  logic [7:0] hbus, bus_in, bus_out, bus_oe, rd_data, out_byte;
  ohi_mode_e iface_mode;
  logic [8:0] exp_q[$];
  logic [8:0] e;
  logic [7:0] b;
  int checked = 0;
  int failures = 0;
  int acks = 0;
  int exp_acks = 0;
  logic ack_p = 1'b0;
  int km[5] = '{3, 4, 2, 1, 0};
  logic [2:0] pat[6] = '{3'h2, 3'h4, 3'h0, 3'h1, 3'h3, 3'h7};
  ohi_mode_e md[6] = '{OHI_I2C, OHI_SPI3, OHI_SPI4, OHI_PAR_E, OHI_PAR_S, OHI_BAD};

  // ----------------------------------------
  // clocks, bus level, design and host
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #32 link_clk = ~link_clk;
  end
  // i2c: sda output bit and input bit share one wire, pulled low by the device
  wire logic sda_pull = (iface_mode == OHI_I2C) && bus_oe[2] && !bus_out[2];
  assign bus_in = ((bus_oe & bus_out) | (~bus_oe & hbus)) & ~{6'h00, sda_pull, 1'b0};

  // count device acks on the sda output bit
  always @(negedge link_clk) begin
    if (bus_oe === 8'h04 && bus_out[2] === 1'b0 && !ack_p) acks++;
    ack_p <= (bus_oe === 8'h04);
  end
  ohi_host_model host (.link_clk(link_clk), .cs_n(cs_n), .dc(dc), .rw(rw), .en(en), .bus(hbus));
  ohi_host_if dut (.core_clk(core_clk), .rst_b(rst_b), .link_clk(link_clk),
    .iface_strap_0(iface_strap_0), .iface_strap_1(iface_strap_1), .iface_strap_2(iface_strap_2),
    .reset_n_input(reset_n_input), .chip_sel_n(cs_n), .data_cmd_sel(dc), .rw_wr_n(rw),
    .en_rd_n(en), .host_data_bus_in(bus_in), .host_data_bus_out(bus_out),
    .host_data_bus_oe(bus_oe), .rd_data(rd_data), .out_byte(out_byte),
    .out_is_data(out_is_data), .out_valid(out_valid), .out_ready(out_ready),
    .iface_mode(iface_mode));

  // core side: random ready unless stalled
  always @(posedge core_clk) out_ready <= #1 stall ? 1'b0 : 1'($urandom);

  // watch delivered bytes against the oldest note
  always @(negedge core_clk) begin
    if (rst_b === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        failures++;
        $display("ERROR %0t unexpected byte %h", $time, out_byte);
      end else begin
        e = exp_q.pop_front();
        `CHK({out_is_data, out_byte}, e)
      end
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic close_out;
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // reset pin pulse with new straps, then mode and idle pins
  task automatic set_mode(input logic [2:0] s, input ohi_mode_e m);
    @(posedge core_clk);
    #1 reset_n_input = 1'b0;
    {iface_strap_0, iface_strap_1, iface_strap_2} = s;
    host.idle(m == OHI_PAR_S);
    repeat (16) @(posedge core_clk);
    #1 reset_n_input = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    `CHK(iface_mode, m)
    `CHK({bus_oe, out_valid}, 9'h000)
    repeat (16) @(posedge core_clk);
  endtask

  // one byte in the chosen mode; noted only when selected
  task automatic send(input int k, input logic c, input logic d, input logic [7:0] v);
    if (!c) exp_q.push_back({d, v});
    if (!c && k == 4) exp_acks += 3;
    case (k)
      0: host.par_wr(1'b0, c, d, v);
      1: host.par_wr(1'b1, c, d, v);
      2: host.ser(c, d, {1'b0, v}, 8);
      3: host.ser(c, d, {d, v}, 9);
      default: host.i2c_wr(v[7], {I2C_ADDR_HI, v[7] ^ c, 1'b0}, {1'b0, d, 6'h00}, v);
    endcase
  endtask

  task automatic drain;
    for (int i = 0; i < 3000 && exp_q.size() != 0; i++) @(posedge core_clk);
    if (exp_q.size() != 0) begin
      failures++;
      $display("ERROR %0t bytes never delivered", $time);
      close_out();
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_b = 1'b0;
    reset_n_input = 1'b0;
    {iface_strap_0, iface_strap_1, iface_strap_2} = 3'h0;
    rd_data = 8'h00;
    stall = 1'b0;
    out_ready = 1'b0;
    void'($urandom(32'h5ba1639d));
    repeat (6) @(posedge core_clk);
    #1 rst_b = 1'b1;
    for (int i = 0; i < 6; i++) set_mode(pat[i], md[i]);
    for (int k = 0; k < 5; k++) begin
      set_mode(pat[km[k]], md[km[k]]);
      stall = 1'b1;
      for (int j = 0; j < 7; j++) begin
        if (j == 3) begin
          stall = 1'b0;
          host.tick(8);
        end
        b = 8'($urandom);
        send(k, 1'b0, 1'($urandom), b);
      end
      send(k, 1'b1, 1'b1, 8'h5a);
      if (k < 2) begin
        rd_data = 8'($urandom);
        host.rd_on(k[0]);
        host.tick(5);
        `CHK(bus_oe, 8'hff)
        `CHK(bus_out, rd_data)
        host.rd_off(k[0]);
        host.tick(4);
        `CHK(bus_oe, 8'h00)
      end else begin
        host.ser(1'b0, 1'b1, 9'h1ff, 4);
        send(k, 1'b0, 1'b0, 8'ha5);
      end
      drain();
    end
    `CHK(acks, exp_acks)
    close_out();
  end
endmodule
